// file: nfs_pkg.sv
package nfs_pkg;
  // Device command codes
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_ERASE_QUEUE = 8'hD1;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] CMD_READ = 8'h00;
  // Feature addresses of the device
  localparam logic [7:0] FEAT_DRIVE = 8'h80;
  localparam logic [7:0] FEAT_PULLDOWN = 8'h81;
  localparam int FEAT_BYTES = 4;
  // Status bits of the device
  localparam int SR_FAIL_BIT = 0;
  localparam int SR_RDY_BIT = 6;
  localparam int SR_ARDY_BIT = 5;
  // Array geometry
  localparam int NUM_BLOCKS = 2048;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int PAGE_BYTES = 2112;
  localparam int ROW_CYCLES = 3;
  localparam int PLANE_BIT = 6;
  // Own register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  // Control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 3;
  localparam int CTRL_GO_BIT = 8;
  // Operation codes
  localparam logic [2:0] OP_ERASE = 3'h0;
  localparam logic [2:0] OP_ERASE2 = 3'h1;
  localparam logic [2:0] OP_RESET = 3'h2;
  localparam logic [2:0] OP_GETF = 3'h3;
  localparam logic [2:0] OP_SETF = 3'h4;
  localparam logic [2:0] OP_STATUS_ENH = 3'h5;
  // Strobe timing
  localparam int STROBE_NS = 40;
  localparam int CLK_NS = 20;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // Register reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {NFS_CMD, NFS_ADR, NFS_WR, NFS_RD} nfs_cyc_t;
endpackage

// file: nfs_strobe.sv
`timescale 1ns/10ps
// One bus cycle on the flash pins: latch strobes and one write or read strobe
module nfs_strobe #(
  parameter int HOLD = nfs_pkg::STROBE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire nfs_pkg::nfs_cyc_t kind,
  input wire logic [7:0] wbyte,
  input wire logic [7:0] io_in,
  output logic done,
  output logic [7:0] rbyte,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic [7:0] io_out,
  output logic io_oe
);
  typedef struct packed {
    logic busy;
    logic phase;
    logic [7:0] cnt;
    nfs_pkg::nfs_cyc_t kind;
    logic [7:0] rbyte;
    logic [7:0] io;
    logic done;
  } nfs_stb_t;
  nfs_stb_t s_q, s_d;

  // Low half of the strobe then high half, data sampled at the rising edge
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy) begin
      if (start) begin
        s_d.busy = 1'b1;
        s_d.phase = 1'b0;
        s_d.cnt = 8'(HOLD);
        s_d.kind = kind;
        s_d.io = wbyte;
      end
    end else if (s_q.cnt > 8'h01) begin
      s_d.cnt = s_q.cnt - 8'h01;
    end else if (!s_q.phase) begin
      // Rising strobe: reads capture the bus here
      s_d.phase = 1'b1;
      s_d.cnt = 8'(HOLD);
      if (s_q.kind == nfs_pkg::NFS_RD) begin
        s_d.rbyte = io_in;
      end
    end else begin
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign rbyte = s_q.rbyte;
  assign cmd_latch = s_q.busy && s_q.kind == nfs_pkg::NFS_CMD;
  assign addr_latch = s_q.busy && s_q.kind == nfs_pkg::NFS_ADR;
  assign write_strobe_n = !(s_q.busy && !s_q.phase && s_q.kind != nfs_pkg::NFS_RD);
  assign read_strobe_n = !(s_q.busy && !s_q.phase && s_q.kind == nfs_pkg::NFS_RD);
  assign io_out = s_q.io;
  assign io_oe = s_q.busy && s_q.kind != nfs_pkg::NFS_RD;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Low half of a write-type cycle; written for the default two-cycle hold
  sequence s_wr_low;
    !write_strobe_n [*2];
  endsequence
  // High half, then the done pulse
  sequence s_wr_high;
    write_strobe_n [*2] ##1 done;
  endsequence
  property p_wr_shape;
    @(posedge clk) disable iff (rst || !ce)
      (start && !s_q.busy && kind != nfs_pkg::NFS_RD) |=> s_wr_low ##1 s_wr_high;
  endproperty
  a_wr_shape: assert property (p_wr_shape) else $error("write strobe shape wrong");
  property p_bus_held;
    @(posedge clk) disable iff (rst || !ce)
      s_q.busy |=> $stable(io_out);
  endproperty
  a_bus_held: assert property (p_bus_held) else $error("bus moved mid cycle");
  property p_bus_dir;
    @(posedge clk) disable iff (rst)
      !read_strobe_n |-> (!io_oe && write_strobe_n);
  endproperty
  a_bus_dir: assert property (p_bus_dir) else $error("bus driven during read");
endmodule // nfs_strobe

// file: nfs_ctrl.sv
`timescale 1ns/10ps
module nfs_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Flash pins
  input wire logic ready_busy_n,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic chip_enable_n
);
  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_DATA, S_WAIT_LO, S_WAIT_HI,
    S_POLL_CMD, S_POLL_RD, S_REREAD, S_READ, S_DONE
  } nfs_st_t;

  typedef struct packed {
    nfs_st_t st;
    logic [2:0] op;
    logic second;
    logic [23:0] row;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [7:0] status;
    logic [1:0] idx;
    logic busy;
    logic err;
    logic start;
    nfs_pkg::nfs_cyc_t kind;
    logic [7:0] wbyte;
    logic wr_pend;
    logic [7:0] wr_addr;
  } nfs_reg_t;

  nfs_reg_t r_q, r_d;
  logic stb_done;
  logic [7:0] stb_rbyte;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Pin cycle engine
  nfs_strobe u_strobe (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(r_q.start),
    .kind(r_q.kind),
    .wbyte(r_q.wbyte),
    .io_in(io_in),
    .done(stb_done),
    .rbyte(stb_rbyte),
    .cmd_latch(cmd_latch),
    .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n),
    .io_out(io_out),
    .io_oe(io_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  always_comb begin
    unique case (r_q.wr_addr)
      nfs_pkg::REG_CTRL: rd_mux = {29'h0, r_q.op};
      nfs_pkg::REG_ADDR: rd_mux = {8'h00, r_q.row};
      nfs_pkg::REG_WDATA: rd_mux = r_q.wdata;
      nfs_pkg::REG_STAT: rd_mux = {22'h0, r_q.err, r_q.busy, r_q.status};
      nfs_pkg::REG_RDATA: rd_mux = r_q.rdata;
      default: rd_mux = nfs_pkg::RST_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and bus slave
  always_comb begin
    r_d = r_q;
    r_d.start = 1'b0;
    // Address phase capture; writes land in the next cycle
    if (hsel && hready && htrans[1]) begin
      r_d.wr_pend = hwrite;
      r_d.wr_addr = haddr;
    end else if (hready) begin
      r_d.wr_pend = 1'b0;
    end
    if (r_q.wr_pend) begin
      unique case (r_q.wr_addr)
        nfs_pkg::REG_ADDR: r_d.row = hwdata[23:0];
        nfs_pkg::REG_WDATA: r_d.wdata = hwdata;
        nfs_pkg::REG_CTRL: begin
          if (r_q.st == S_IDLE) begin
            // A late write must not switch the sequence halfway through
            r_d.op = hwdata[nfs_pkg::CTRL_OP_LSB +: nfs_pkg::CTRL_OP_W];
          end
          if (hwdata[nfs_pkg::CTRL_GO_BIT] && r_q.st == S_IDLE) begin
            r_d.busy = 1'b1;
            r_d.err = 1'b0;
            r_d.second = 1'b0;
            r_d.st = S_CMD1;
          end
        end
        default: ;
      endcase
    end
    unique case (r_q.st)
      S_IDLE: ;
      S_CMD1: begin
        r_d.start = 1'b1;
        r_d.kind = nfs_pkg::NFS_CMD;
        r_d.idx = 2'd0;
        unique case (r_q.op)
          nfs_pkg::OP_ERASE, nfs_pkg::OP_ERASE2: r_d.wbyte = nfs_pkg::CMD_ERASE_SETUP;
          nfs_pkg::OP_RESET: r_d.wbyte = nfs_pkg::CMD_RESET;
          nfs_pkg::OP_GETF: r_d.wbyte = nfs_pkg::CMD_GET_FEAT;
          nfs_pkg::OP_SETF: r_d.wbyte = nfs_pkg::CMD_SET_FEAT;
          default: r_d.wbyte = nfs_pkg::CMD_STATUS_ENH;
        endcase
        r_d.st = S_ADDR;
      end
      S_ADDR: if (stb_done) begin
        r_d.start = 1'b1;
        r_d.kind = nfs_pkg::NFS_ADR;
        if (r_q.op == nfs_pkg::OP_RESET) begin
          // reset: no address, wait for busy time
          r_d.start = 1'b0;
          r_d.st = S_WAIT_LO;
        end else if (r_q.op == nfs_pkg::OP_GETF || r_q.op == nfs_pkg::OP_SETF) begin
          r_d.wbyte = r_q.row[7:0];
          r_d.st = (r_q.op == nfs_pkg::OP_SETF) ? S_DATA : S_WAIT_LO;
          r_d.idx = 2'd0;
        end else begin
          // plane bit forced per address set
          r_d.wbyte = r_q.row[8*r_q.idx +: 8];
          if (r_q.op == nfs_pkg::OP_ERASE2 && r_q.idx == 2'd0) begin
            r_d.wbyte[nfs_pkg::PLANE_BIT] = r_q.second;
          end
          if (r_q.op == nfs_pkg::OP_STATUS_ENH && r_q.idx == 2'(nfs_pkg::ROW_CYCLES - 1)) begin
            r_d.st = S_POLL_RD;
          end else if (r_q.idx == 2'(nfs_pkg::ROW_CYCLES - 1)) begin
            r_d.st = S_CMD2;
          end
          r_d.idx = r_q.idx + 2'd1;
        end
      end
      S_CMD2: if (stb_done) begin
        // queue with D1h first pass, finish with D0h
        r_d.start = 1'b1;
        r_d.kind = nfs_pkg::NFS_CMD;
        r_d.wbyte = (r_q.op == nfs_pkg::OP_ERASE2 && !r_q.second) ?
                    nfs_pkg::CMD_ERASE_QUEUE : nfs_pkg::CMD_ERASE_CONFIRM;
        r_d.st = S_WAIT_LO;
      end
      S_DATA: if (stb_done) begin
        // four parameter bytes, byte 1 first
        r_d.start = 1'b1;
        r_d.kind = nfs_pkg::NFS_WR;
        r_d.wbyte = r_q.wdata[8*r_q.idx +: 8];
        r_d.idx = r_q.idx + 2'd1;
        if (r_q.idx == 2'(nfs_pkg::FEAT_BYTES - 1)) begin
          r_d.st = S_WAIT_LO;
        end
      end
      // Strobe idle: no start pending and no write cycle in flight
      S_WAIT_LO: if (stb_done || (!io_oe && !r_q.start)) begin
        if (!ready_busy_n) begin
          r_d.st = S_WAIT_HI;
        end
      end
      S_WAIT_HI: if (ready_busy_n) begin
        r_d.st = S_POLL_CMD;
      end
      S_POLL_CMD: begin
        r_d.start = 1'b1;
        r_d.kind = nfs_pkg::NFS_CMD;
        r_d.wbyte = nfs_pkg::CMD_STATUS;
        r_d.st = S_POLL_RD;
      end
      S_POLL_RD: if (stb_done) begin
        r_d.start = 1'b1;
        r_d.kind = nfs_pkg::NFS_RD;
        r_d.st = S_REREAD;
      end
      S_REREAD: if (stb_done) begin
        r_d.status = stb_rbyte;
        r_d.err = stb_rbyte[nfs_pkg::SR_FAIL_BIT];
        if (r_q.op == nfs_pkg::OP_ERASE2 && !r_q.second) begin
          // second half is again an erase
          r_d.second = 1'b1;
          r_d.st = S_CMD1;
        end else if (r_q.op == nfs_pkg::OP_GETF) begin
          r_d.start = 1'b1;
          r_d.kind = nfs_pkg::NFS_CMD;
          r_d.wbyte = nfs_pkg::CMD_READ;
          r_d.idx = 2'd0;
          r_d.st = S_READ;
        end else begin
          r_d.st = S_DONE;
        end
      end
      S_READ: if (stb_done) begin
        if (r_q.kind == nfs_pkg::NFS_RD) begin
          r_d.rdata[8*r_q.idx +: 8] = stb_rbyte;
          r_d.idx = r_q.idx + 2'd1;
        end
        if (r_q.kind == nfs_pkg::NFS_RD && r_q.idx == 2'(nfs_pkg::FEAT_BYTES - 1)) begin
          r_d.st = S_DONE;
        end else begin
          r_d.start = 1'b1;
          r_d.kind = nfs_pkg::NFS_RD;
        end
      end
      S_DONE: begin
        r_d.busy = 1'b0;
        r_d.st = S_IDLE;
      end
      default: r_d.st = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_mux;
  assign chip_enable_n = !r_q.busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_done_clears;
    @(posedge clk) disable iff (rst) (ce && r_q.st == S_DONE) |=> !r_q.busy;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("busy not cleared");
  property p_ahb_ok;
    @(posedge clk) disable iff (rst) hreadyout && !hresp;
  endproperty
  a_ahb_ok: assert property (p_ahb_ok) else $error("bad bus answer");

  property p_go_refused;
    @(posedge clk) disable iff (rst)
      (ce && r_q.wr_pend && r_q.wr_addr == nfs_pkg::REG_CTRL && r_q.st != S_IDLE) |=>
        $stable(r_q.op);
  endproperty
  a_go_refused: assert property (p_go_refused) else $error("op changed while busy");

  // plane bit per pass
  // Two edges from the decision to the pins: one to launch, one for the strobe to take it
  property p_plane_bit;
    @(posedge clk) disable iff (rst || !ce)
      (r_q.st == S_ADDR && stb_done && r_q.op == nfs_pkg::OP_ERASE2 && r_q.idx == 2'h0)
        |=> ##1 (addr_latch && io_out[nfs_pkg::PLANE_BIT] == r_q.second);
  endproperty
  a_plane_bit: assert property (p_plane_bit) else $error("plane bit wrong");

  property p_queue_code;
    @(posedge clk) disable iff (rst || !ce)
      (r_q.st == S_CMD2 && stb_done && r_q.op == nfs_pkg::OP_ERASE2 && !r_q.second)
        |=> ##1 (cmd_latch && io_out == nfs_pkg::CMD_ERASE_QUEUE);
  endproperty
  a_queue_code: assert property (p_queue_code) else $error("queue code wrong");

  property p_confirm_code;
    @(posedge clk) disable iff (rst || !ce)
      (r_q.st == S_CMD2 && stb_done && r_q.op == nfs_pkg::OP_ERASE2 && r_q.second)
        |=> ##1 (cmd_latch && io_out == nfs_pkg::CMD_ERASE_CONFIRM);
  endproperty
  a_confirm_code: assert property (p_confirm_code) else $error("confirm code wrong");

  // ready awaited only after busy
  // Guards against taking a stale ready level before the device has reacted
  property p_saw_busy;
    @(posedge clk) disable iff (rst)
      $rose(r_q.st == S_WAIT_HI) |-> $past(!ready_busy_n);
  endproperty
  a_saw_busy: assert property (p_saw_busy) else $error("ready taken before busy");
endmodule // nfs_ctrl

// file: nfs_dev_model.sv
`timescale 1ns/10ps
// Behavioural flash device on the far side of the pins; logs every write cycle
module nfs_dev_model #(
  parameter int ERASE_NS = 2000,
  parameter int SHORT_NS = 400,
  parameter int HOLD_NS = 10
) (
  input wire logic chip_enable_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] io_out,
  output logic ready_busy_n,
  output logic [7:0] io_in
);
  logic [9:0] log_q[$]; // Kind {cmd,addr} and byte of each write cycle
  logic [7:0] feat_q[256]; // Feature table
  logic [7:0] out_q[$]; // Pending output bytes
  logic [7:0] pbuf_q[4]; // Parameter bytes being collected
  logic [7:0] status_q, cmd_q, fadr_q;
  logic rd_stat_q, fail_next; // fail_next is set by the bench to force a failed erase
  logic wp_q; // write-protect level, high lets erases through
  int gen, ndat;
  ////////////////////////////////////////////////////////////////////////////////
  // Power-up state, full strength
  initial begin
    foreach (feat_q[i]) feat_q[i] = 8'h00;
    status_q = 8'hE0;
    cmd_q = 8'h00;
    ready_busy_n = 1'b1;
    io_in = 8'h5A;
    rd_stat_q = 1'b0;
    fail_next = 1'b0;
    wp_q = 1'b1;
    gen = 0;
  end
  // Busy window; a newer window or a reset cancels the old one
  task automatic busy(input int ns, input logic [7:0] fin);
    gen++;
    ready_busy_n = 1'b0;
    status_q = status_q & 8'h9F;
    fork
      begin
        automatic int my = gen;
        #(ns);
        if (my == gen) begin
          ready_busy_n = 1'b1;
          status_q = fin;
        end
      end
    join_none
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Bytes are taken on the rising write strobe
  always @(posedge write_strobe_n) begin
    if (!chip_enable_n && cmd_latch) begin
      log_q.push_back({2'b10, io_out});
      // While busy only reset and status reads get through
      if (ready_busy_n || io_out inside {8'hFF, 8'h70, 8'h78}) begin
        case (io_out)
          8'hFF: begin
            cmd_q = 8'h00;
            out_q.delete();
            rd_stat_q = 1'b0;
            busy(SHORT_NS, wp_q ? 8'hE0 : 8'h60);
          end
          // Plain status keeps feature mode alive
          8'h70: rd_stat_q = 1'b1;
          // Enhanced status takes row cycles after it
          8'h78: begin
            cmd_q = io_out;
            rd_stat_q = 1'b1;
          end
          8'h00: rd_stat_q = 1'b0;
          // Erase confirm; row bits are not needed here
          8'hD0: if (wp_q) busy(ERASE_NS, {7'h70, fail_next});
          // queue code: short busy, ends with ready bits high
          8'hD1: if (wp_q) busy(SHORT_NS, 8'hE0);
          default: begin
            cmd_q = io_out;
            ndat = 0;
            rd_stat_q = 1'b0;
          end
        endcase
      end
    end else if (!chip_enable_n && addr_latch) begin
      log_q.push_back({2'b01, io_out});
      fadr_q = io_out;
      // Get features loads four bytes, reserved read zero
      if (cmd_q == 8'hEE) begin
        out_q = '{feat_q[io_out], 8'h00, 8'h00, 8'h00};
        busy(SHORT_NS, 8'hE0);
      end
    end else if (!chip_enable_n) begin
      log_q.push_back({2'b00, io_out});
      // Set features stores strength code after P4
      if (cmd_q == 8'hEF && ndat < 4) begin
        pbuf_q[ndat] = io_out;
        ndat++;
        if (ndat == 4) begin
          if (fadr_q inside {8'h80, 8'h81}) feat_q[fadr_q] = pbuf_q[0] & 8'h03;
          busy(SHORT_NS, 8'hE0);
        end
      end
    end
  end
  // Read data appears on the falling read strobe
  always @(negedge read_strobe_n) begin
    if (!chip_enable_n) io_in = rd_stat_q ? status_q : (out_q.size() > 0 ? out_q.pop_front() : 8'h00);
  end
  // Released bus has no pull: show the inverse once hold time is over
  always @(posedge read_strobe_n) io_in <= #(HOLD_NS) ~io_in;
endmodule // nfs_dev_model

// file: nand_erase_reset_feature_seq_tb.sv
`timescale 1ns/10ps
module nand_erase_reset_feature_seq_tb;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, ready_busy_n, io_oe;
  logic cmd_latch, addr_latch, write_strobe_n, read_strobe_n, chip_enable_n;
  logic [7:0] haddr, io_in, io_out;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd, row;
  int failures, checked;
  int seed = 32'h73838967;
  logic [9:0] exp_q[$]; // Expected write cycles
  logic [7:0] fexp[256]; // Expected feature table
  logic [7:0] fas[3] = '{8'h80, 8'h81, 8'h05};
  nfs_ctrl i_dut (.clk(clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ready_busy_n(ready_busy_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .chip_enable_n(chip_enable_n));
  nfs_dev_model #(.ERASE_NS(2000), .SHORT_NS(400), .HOLD_NS(10)) i_dev (
    .chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .ready_busy_n(ready_busy_n), .io_in(io_in));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wrap_up();
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #(1_000_000);
    failures++;
    wrap_up();
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  // One AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Start an operation, optionally try a refused second go, poll until idle
  task automatic run_op(input logic [2:0] op, input logic [31:0] a, input logic [31:0] wd, input bit extra);
    int n;
    bus(1'b1, nfs_pkg::REG_ADDR, a, rd);
    bus(1'b1, nfs_pkg::REG_WDATA, wd, rd);
    bus(1'b1, nfs_pkg::REG_CTRL, 32'h0000_0100 | 32'(op), rd);
    n = 0;
    do begin
      bus(1'b0, nfs_pkg::REG_STAT, 32'h0, rd);
      n++;
    end while (rd[8] !== 1'b1 && n < 4);
    chk("busy flag", 32'h1, 32'(rd[8]));
    if (extra) bus(1'b1, nfs_pkg::REG_CTRL, 32'h0000_0100 | 32'(nfs_pkg::OP_RESET), rd);
    do bus(1'b0, nfs_pkg::REG_STAT, 32'h0, rd); while (rd[8] !== 1'b0);
  endtask
  task automatic ex(input logic [1:0] k, input logic [7:0] b);
    exp_q.push_back({k, b});
  endtask
  task automatic ex_row(input logic [23:0] r);
    ex(2'b01, r[7:0]);
    ex(2'b01, r[15:8]);
    ex(2'b01, r[23:16]);
  endtask
  // Compare logged pin cycles, status polling aside, with the expected list
  task automatic cmp_log();
    logic [9:0] e;
    foreach (i_dev.log_q[i]) begin
      e = i_dev.log_q[i];
      if (!(e[9] && e[7:0] inside {8'h70, 8'h00}))
        chk("pin cycle", exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 32'h3FF, 32'(e));
    end
    chk("cycles left", 32'h0, 32'(exp_q.size()));
    i_dev.log_q.delete();
    exp_q.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    checked = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    foreach (fexp[i]) fexp[i] = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Unmapped write first: it must leave every register at zero
    bus(1'b1, 8'h14, 32'hFFFF_FFFF, rd);
    for (int a = 0; a <= 16; a += 4) begin
      bus(1'b0, 8'(a), 32'h0, rd);
      chk("reset value", 32'h0, rd);
    end
    // Erase passing then failing, each with a go that must be refused
    for (int f = 0; f < 2; f++) begin
      row = $random(seed) & 32'h3FFFF; // page, plane and block bits
      i_dev.fail_next = f[0];
      run_op(nfs_pkg::OP_ERASE, row, 32'h0, 1'b1);
      ex(2'b10, 8'h60);
      ex_row(row[23:0]);
      ex(2'b10, 8'hD0);
      cmp_log();
      chk("erase status", 32'({f[0], 1'b0, 7'h70, f[0]}), 32'(rd[9:0]));
    end
    run_op(nfs_pkg::OP_STATUS_ENH, row, 32'h0, 1'b0);
    ex(2'b10, 8'h78);
    ex_row(row[23:0]);
    cmp_log();
    chk("enhanced status", 32'h2E1, 32'(rd[9:0]));
    run_op(nfs_pkg::OP_RESET, 32'h0, 32'h0, 1'b0);
    ex(2'b10, 8'hFF);
    cmp_log();
    chk("reset status", 32'h0E0, 32'(rd[9:0]));
    // Two-plane erase: plane bit low then high, same row otherwise
    row = $random(seed) & 32'h3FFFF;
    run_op(nfs_pkg::OP_ERASE2, row, 32'h0, 1'b0);
    ex(2'b10, 8'h60);
    ex_row({row[23:8], row[7:0] & 8'hBF});
    ex(2'b10, 8'hD1);
    ex(2'b10, 8'h60);
    ex_row({row[23:8], row[7:0] | 8'h40});
    ex(2'b10, 8'hD0);
    cmp_log();
    // Every strength code on both features and one reserved address
    foreach (fas[j]) begin
      for (int v = 0; v < 4; v++) begin
        run_op(nfs_pkg::OP_SETF, 32'(fas[j]), 32'(v), 1'b0);
        ex(2'b10, 8'hEF);
        ex(2'b01, fas[j]);
        ex(2'b00, 8'(v));
        for (int k = 0; k < 3; k++) ex(2'b00, 8'h00);
        cmp_log();
        if (fas[j] != 8'h05) fexp[fas[j]] = 8'(v);
        run_op(nfs_pkg::OP_GETF, 32'(fas[j]), 32'h0, 1'b0);
        ex(2'b10, 8'hEE);
        ex(2'b01, fas[j]);
        cmp_log();
        bus(1'b0, nfs_pkg::REG_RDATA, 32'h0, rd);
        chk("feature bytes", 32'(fexp[fas[j]]), rd);
      end
    end
    // Settings survive a reset
    run_op(nfs_pkg::OP_RESET, 32'h0, 32'h0, 1'b0);
    run_op(nfs_pkg::OP_GETF, 32'h80, 32'h0, 1'b0);
    ex(2'b10, 8'hFF);
    ex(2'b10, 8'hEE);
    ex(2'b01, 8'h80);
    cmp_log();
    bus(1'b0, nfs_pkg::REG_RDATA, 32'h0, rd);
    chk("kept feature", 32'(fexp[8'h80]), rd);
    wrap_up();
  end
endmodule // nand_erase_reset_feature_seq_tb
